// >>> sds_monitor.sv
// assertion checker on the ports of the sinusoid synthesizer
`timescale 1ns/100ps
module sds_monitor
    import sds_pkg::*;
#(
    parameter int NUM_CH = 1 // channels served in turn
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic in_ready,
    input wire logic cfg_ready,
    input wire logic out_valid,
    input wire sds_pkg::sds_out_s out_data,
    input wire logic out_ready,
    input wire logic [31:0] reg_rdata
);
    logic take; // output transfer at this edge
    logic seen_reg; // a transfer since reset
    logic [CH_W-1:0] chan_reg; // channel of the last transfer
    logic [CH_W-1:0] chan_next; // channel due next
    assign take = clk_en && out_valid && out_ready;
    assign chan_next = (chan_reg == CH_W'(NUM_CH - 1)) ? '0 : chan_reg + 1'b1;
    ////////////////////////////////////////////////////////////////
    // remember the last channel, so rotation is checked across stalls
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            seen_reg <= 1'b0;
            chan_reg <= '0;
        end else if (take) begin
            seen_reg <= 1'b1;
            chan_reg <= out_data.chan;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_hold;
        out_valid && !(clk_en && out_ready) |=> out_valid && $stable(out_data);
    endproperty
    a_hold: assert property (p_hold) else $error("sample changed before taken");
    property p_freeze;
        !clk_en |=> $stable(out_valid) && $stable(cfg_ready) && $stable(out_data);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with enable low");
    // the clear cannot be disabled by itself, so this one runs always
    property p_clear;
        disable iff (1'b0) $fell(rst_b) |-> ##2 (!out_valid && !cfg_ready && reg_rdata == 32'h0);
    endproperty
    a_clear: assert property (p_clear) else $error("outputs not cleared");
    property p_last;
        out_valid |-> (out_data.last == (out_data.chan == CH_W'(NUM_CH - 1)));
    endproperty
    a_last: assert property (p_last) else $error("last flag wrong");
    property p_order;
        take && seen_reg |-> out_data.chan == chan_next;
    endproperty
    a_order: assert property (p_order) else $error("channel order broken");
    property p_quad0;
        out_valid && out_data.phase == 16'h0000 |-> out_data.sine == 16'h0000
            && out_data.cosine == 16'h7FFF;
    endproperty
    a_quad0: assert property (p_quad0) else $error("lookup wrong at zero");
    property p_quad1;
        out_valid && out_data.phase == PH_QTR |-> out_data.sine == 16'h7FFF
            && out_data.cosine == 16'h0000;
    endproperty
    a_quad1: assert property (p_quad1) else $error("lookup wrong at quarter");
    property p_cfg;
        cfg_ready |=> cfg_ready;
    endproperty
    a_cfg: assert property (p_cfg) else $error("config ready dropped");
    property p_noin;
        !in_ready;
    endproperty
    a_noin: assert property (p_noin) else $error("input channel present");
    c_stall: cover property (out_valid && !out_ready);
    c_freeze: cover property (!clk_en && out_valid);
    c_wrap: cover property (take && out_data.last);
endmodule : sds_monitor

// >>> sds_pkg.sv
// shared constants, carriers and lookup for the sinusoid synthesizer
package sds_pkg;
    localparam int PH_W = 16; // phase width
    localparam int OUT_W = 16; // output sample width
    localparam int CH_MAX = 16; // most time-multiplexed channels
    localparam int CH_W = 4; // channel index width
    localparam int RAS_W = 14; // raster accumulator width
    localparam int RAS_M_MIN = 9; // least raster modulus
    localparam int RAS_M_MAX = 16384; // largest raster modulus
    localparam int RAS_SH = 30; // reciprocal scale for raster phase
    localparam int FRAC_W = 10; // phase bits below the table index
    localparam logic [PH_W-1:0] PH_QTR = 16'h4000; // quarter turn
    localparam logic [3:0] REG_CTRL = 4'h0; // control word
    localparam logic [3:0] REG_STAT = 4'h4; // status word
    localparam logic [3:0] REG_COUNT = 4'h8; // sample counter
    localparam int CTRL_DITH = 0; // dither enable bit
    localparam int CTRL_HOLD = 1; // generation pause bit
    localparam logic [1:0] CTRL_RST = 2'h1; // control reset value
    localparam logic [15:0] LFSR_SEED = 16'hACE1; // dither seed
    // quarter-wave table, 17 points incl. the end point
    localparam logic [0:16][15:0] SDS_TAB = {
        16'h0000, 16'h0C8C, 16'h18F9, 16'h2528, 16'h30FB, 16'h3C56,
        16'h471C, 16'h5133, 16'h5A82, 16'h62F1, 16'h6A6D, 16'h70E2,
        16'h7641, 16'h7A7C, 16'h7D89, 16'h7F61, 16'h7FFF};

    // build choices and value sources
    typedef enum {SDS_FULL, SDS_PG_ONLY, SDS_LUT_ONLY} sds_build_e;
    typedef enum {SDS_FIXED, SDS_PROG, SDS_STREAM, SDS_NONE} sds_src_e;
    typedef enum {SDS_SIN, SDS_COS, SDS_BOTH} sds_outsel_e;

    // input phase channel word
    typedef struct packed {
        logic [PH_W-1:0] phase; // lookup-only input phase
        logic [PH_W-1:0] phase_word_step_field; // streamed step
        logic [PH_W-1:0] phase_word_shift_field; // streamed shift
    } sds_in_s;

    // configuration channel word
    typedef struct packed {
        logic [CH_W-1:0] chan; // channel addressed
        logic [PH_W-1:0] cfg_word_step_field; // programmed step
        logic [PH_W-1:0] cfg_word_shift_field; // programmed shift
    } sds_cfg_s;

    // output channel word
    typedef struct packed {
        logic last; // last channel of a vector
        logic [CH_W-1:0] chan; // channel of this sample
        logic [PH_W-1:0] phase; // phase that was looked up
        logic [OUT_W-1:0] sine; // sine sample
        logic [OUT_W-1:0] cosine; // cosine sample
    } sds_out_s;

    // phase to sine, optional first-order correction
    function automatic logic [OUT_W-1:0] sds_sine(input logic [PH_W-1:0] ph,
            input logic taylor, input logic unit);
        logic [14:0] u;
        logic [4:0] i;
        logic [4:0] j;
        logic signed [17:0] a;
        logic signed [17:0] d;
        logic signed [28:0] p;
        logic signed [17:0] y;
        u = ph[14] ? 15'h4000 - {1'b0, ph[13:0]} : {1'b0, ph[13:0]};
        i = u[14:10];
        j = (i == 5'h10) ? i : i + 5'h01;
        a = signed'({2'h0, SDS_TAB[i]});
        d = signed'({2'h0, SDS_TAB[j]}) - a;
        p = d * signed'({1'b0, u[FRAC_W-1:0]});
        y = taylor ? a + 18'(p >>> FRAC_W) : a;
        if (unit) y = y >>> 1;
        if (ph[15]) y = -y;
        return y[OUT_W-1:0];
    endfunction : sds_sine
endpackage : sds_pkg

// >>> sds_sink.sv
// downstream stream sink that stalls on request
`timescale 1ns/100ps
module sds_sink (
    input wire logic clk_sys,
    input wire logic stall,
    input wire logic coin,
    output logic out_ready
);
    ////////////////////////////////////////////////////////////////
    // ready follows a random coin while stalling, else always ready
    always @(posedge clk_sys) begin
        out_ready <= stall ? coin : 1'b1;
    end
endmodule : sds_sink

// >>> sds_synth.sv
// time-multiplexed sinusoid synthesizer with stream ports
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps

// What this block does
// - accumulator then optional offset adder
// - step and shift sources chosen independently
// - fixed values are build-time constants
// - config word fields; no config without programmables
// - phase word fields; no input if none streamed
// - lookup-only takes phase from input channel
// - full, generator-only or lookup-only builds
// - sine, cosine or both outputs
// - sine and cosine negation selected separately
// - one to sixteen multiplexed channels
// - each channel owns step and shift
// - standard mode frequency from clock, width, step
// - raster mode exact modulo M accumulation
// - lookup-only: no dither, correction allowed
// - generator-only: no noise shaping
// - optional first-order correction of lookup
// - optional dither perturbs phase before lookup
// - step and shift width follow resolution
// - output width bounds phase width
// - full-range or half unit-circle amplitude
// - pipelined; stall when output blocked
// - clear is registered, beats clock enable
// - clock enable low freezes datapath
// - backpressure stalls whole datapath
// - new config applied at vector start
module sds_synth
    import sds_pkg::*;
#(
    parameter sds_build_e BUILD = SDS_FULL,
    parameter sds_src_e STEP_SRC = SDS_PROG,
    parameter sds_src_e SHIFT_SRC = SDS_PROG,
    parameter sds_outsel_e OUT_SEL = SDS_BOTH,
    parameter bit NEG_SIN = 1'b0,
    parameter bit NEG_COS = 1'b0,
    parameter int NUM_CH = 1,
    parameter bit RASTER = 1'b0,
    parameter int RAS_M = 1000,
    parameter bit TAYLOR = 1'b1,
    parameter bit DITHER = 1'b0,
    parameter bit UNIT_AMP = 1'b0,
    parameter bit OUT_BP = 1'b1,
    parameter logic [PH_W-1:0] FIXED_STEP = 16'h0100,
    parameter logic [PH_W-1:0] FIXED_SHIFT = 16'h0000
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic in_valid,
    input wire sds_pkg::sds_in_s in_data,
    output logic in_ready,
    input wire logic cfg_valid,
    input wire sds_pkg::sds_cfg_s cfg_data,
    output logic cfg_ready,
    output logic out_valid,
    output sds_pkg::sds_out_s out_data,
    input wire logic out_ready,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    import sds_pkg::*;

    ////////////////////////////////////////////////////////////////
    // build-derived switches

    // which parts exist in this build
    localparam bit HAS_PG = (BUILD != SDS_LUT_ONLY);
    localparam bit HAS_LUT = (BUILD != SDS_PG_ONLY);
    // config channel only when something is programmable
    localparam bit HAS_CFG = HAS_PG &&
        (STEP_SRC == SDS_PROG || SHIFT_SRC == SDS_PROG);
    // input channel only for streamed values or lookup-only
    localparam bit HAS_IN = !HAS_PG ||
        STEP_SRC == SDS_STREAM || SHIFT_SRC == SDS_STREAM;
    // correction needs the table; dither needs both parts
    localparam bit TAY_ON = TAYLOR && HAS_LUT;
    localparam bit DITH_ON = DITHER && BUILD == SDS_FULL;
    // last channel index of the vector
    localparam logic [CH_W-1:0] LAST_CH = CH_W'(NUM_CH - 1);
    // raster modulus and reciprocal for phase scaling
    localparam logic [RAS_W:0] RAS_M_V = (RAS_W + 1)'(RAS_M);
    localparam logic [31:0] RAS_R = 32'((64'h1 << RAS_SH) / RAS_M);

    ////////////////////////////////////////////////////////////////
    // state

    // every flip-flop of the block lives here
    typedef struct packed {
        logic rst_q; // clear, registered once
        logic [CH_W-1:0] ch; // channel served next
        logic [CH_MAX-1:0][PH_W-1:0] acc; // accumulators
        logic [CH_MAX-1:0][PH_W-1:0] step; // active steps
        logic [CH_MAX-1:0][PH_W-1:0] shift; // active shifts
        logic [CH_MAX-1:0][PH_W-1:0] pstep; // pending steps
        logic [CH_MAX-1:0][PH_W-1:0] pshift; // pending shifts
        logic [CH_MAX-1:0] pend; // pending flags
        logic [15:0] lfsr; // dither source
        logic a_vld; // phase stage full
        logic a_last; // phase stage last flag
        logic [CH_W-1:0] a_ch; // phase stage channel
        logic [PH_W-1:0] a_ph; // phase stage phase
        logic o_vld; // output stage full
        sds_out_s o; // output stage word
        logic gen_rdy; // phase stage may load
        logic in_port; // input ready seen outside
        logic cfg_rdy; // config ready
        logic [1:0] ctrl; // software control
        logic [31:0] count; // samples delivered
        logic [31:0] rdata; // read data
    } sds_state_s;

    sds_state_s st_reg; // registered state
    sds_state_s st_next; // next state

    ////////////////////////////////////////////////////////////////
    // next state

    // one process computes everything; order matters below
    always_comb begin
        logic [CH_W-1:0] c;
        logic [PH_W-1:0] stp;
        logic [PH_W-1:0] sft;
        logic [PH_W-1:0] base;
        logic [PH_W-1:0] ph;
        logic [RAS_W:0] rsum;
        logic [31:0] prod;
        logic [OUT_W-1:0] sn;
        logic [OUT_W-1:0] cs;
        logic o_take;
        logic take_in;
        c = st_reg.ch;
        stp = '0;
        sft = '0;
        base = '0;
        ph = '0;
        rsum = '0;
        prod = '0;
        sn = '0;
        cs = '0;
        st_next = st_reg;
        // clear passes one flop before it acts
        st_next.rst_q = rst_b;
        // output stage can move when empty or accepted
        o_take = !st_reg.o_vld || out_ready || !OUT_BP;
        // internal source always offers when no input channel
        take_in = st_reg.gen_rdy && (in_valid || !HAS_IN);

        // register port runs beside the datapath
        st_next.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                st_next.rdata = {30'h0, st_reg.ctrl};
            end else if (reg_addr == REG_STAT) begin
                st_next.rdata = {st_reg.pend, 12'h000, st_reg.ch};
            end else if (reg_addr == REG_COUNT) begin
                st_next.rdata = st_reg.count;
            end else begin
                st_next.rdata = '0; // unmapped reads zero
            end
        end
        if (reg_wr && reg_addr == REG_CTRL) begin
            st_next.ctrl = reg_wdata[1:0];
        end

        // datapath advances only on enabled cycles
        if (clk_en) begin
            // lookup stage: phase word into samples
            if (o_take) begin
                if (st_reg.o_vld) begin
                    st_next.count = st_reg.count + 32'h1;
                end
                sn = sds_sine(st_reg.a_ph, TAY_ON, UNIT_AMP);
                cs = sds_sine(st_reg.a_ph + PH_QTR, TAY_ON, UNIT_AMP);
                if (NEG_SIN) sn = -sn;
                if (NEG_COS) cs = -cs;
                if (!HAS_LUT || OUT_SEL == SDS_COS) sn = '0;
                if (!HAS_LUT || OUT_SEL == SDS_SIN) cs = '0;
                st_next.o_vld = st_reg.a_vld;
                st_next.o.last = st_reg.a_last;
                st_next.o.chan = st_reg.a_ch;
                st_next.o.phase = st_reg.a_ph;
                st_next.o.sine = sn;
                st_next.o.cosine = cs;
                st_next.a_vld = 1'b0;
            end

            // pending values become active at vector start
            if (take_in && c == '0) begin
                for (int k = 0; k < CH_MAX; k++) begin
                    if (st_reg.pend[k]) begin
                        st_next.step[k] = st_reg.pstep[k];
                        st_next.shift[k] = st_reg.pshift[k];
                    end
                end
                st_next.pend = '0;
            end

            // config writes park until the next vector; set beats clear
            if (st_reg.cfg_rdy && cfg_valid) begin
                if (STEP_SRC == SDS_PROG) begin
                    st_next.pstep[cfg_data.chan] = cfg_data.cfg_word_step_field;
                end else begin
                    st_next.pstep[cfg_data.chan] = st_next.step[cfg_data.chan];
                end
                if (SHIFT_SRC == SDS_PROG) begin
                    st_next.pshift[cfg_data.chan] = cfg_data.cfg_word_shift_field;
                end else begin
                    st_next.pshift[cfg_data.chan] = st_next.shift[cfg_data.chan];
                end
                st_next.pend[cfg_data.chan] = 1'b1;
            end

            // phase stage: serve channel c
            if (take_in) begin
                // pick each source on its own
                case (STEP_SRC)
                    SDS_FIXED: stp = FIXED_STEP;
                    SDS_STREAM: stp = in_data.phase_word_step_field;
                    SDS_PROG: stp = st_next.step[c];
                    default: stp = '0;
                endcase
                case (SHIFT_SRC)
                    SDS_FIXED: sft = FIXED_SHIFT;
                    SDS_STREAM: sft = in_data.phase_word_shift_field;
                    SDS_PROG: sft = st_next.shift[c];
                    default: sft = '0; // no offset adder
                endcase
                if (!HAS_PG) begin
                    // lookup-only: phase comes straight in
                    ph = in_data.phase;
                end else if (RASTER) begin
                    // exact modulo M, never truncated
                    rsum = {1'b0, st_reg.acc[c][RAS_W-1:0]} +
                        {1'b0, stp[RAS_W-1:0]};
                    if (rsum >= RAS_M_V) rsum = rsum - RAS_M_V;
                    st_next.acc[c] = {2'h0, rsum[RAS_W-1:0]};
                    // scale residue to a full turn for lookup
                    prod = {18'h0, st_reg.acc[c][RAS_W-1:0]} * RAS_R;
                    base = prod[RAS_SH-1:RAS_SH-PH_W];
                    ph = base + sft;
                end else begin
                    // plain wrap at full phase width
                    st_next.acc[c] = st_reg.acc[c] + stp;
                    ph = st_reg.acc[c] + sft;
                end
                // dither sits below the table index bits
                if (DITH_ON && st_reg.ctrl[CTRL_DITH]) begin
                    ph = ph + {6'h00, st_reg.lfsr[FRAC_W-1:0]};
                end
                st_next.lfsr = {st_reg.lfsr[14:0], st_reg.lfsr[15] ^
                    st_reg.lfsr[13] ^ st_reg.lfsr[12] ^ st_reg.lfsr[10]};
                st_next.a_vld = 1'b1;
                st_next.a_ph = ph;
                st_next.a_ch = c;
                st_next.a_last = (c == LAST_CH);
                // channels take turns on one datapath
                st_next.ch = (c == LAST_CH) ? '0 : c + 4'h1;
            end

            // ready only when the phase stage surely frees
            st_next.gen_rdy = !st_reg.ctrl[CTRL_HOLD] &&
                (!st_next.a_vld || !st_next.o_vld || !OUT_BP);
            st_next.in_port = st_next.gen_rdy && HAS_IN;
            st_next.cfg_rdy = HAS_CFG;
        end

        // registered clear wins over clock enable
        if (!st_reg.rst_q) begin
            st_next = '0;
            st_next.rst_q = rst_b;
            st_next.ctrl = CTRL_RST;
            st_next.lfsr = LFSR_SEED;
        end
    end

    ////////////////////////////////////////////////////////////////
    // registers

    // single clocked process for all state
    always_ff @(posedge clk_sys) begin
        st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    // handshake and data outputs
    assign in_ready = st_reg.in_port;
    assign cfg_ready = st_reg.cfg_rdy;
    assign out_valid = st_reg.o_vld;
    assign out_data = st_reg.o;
    assign reg_rdata = st_reg.rdata;

    // widths are fixed, so the resolution and bound checks are static:
    // step and shift carry the full phase width, and the sample width
    // never exceeds it
endmodule : sds_synth

// >>> testbench.sv
// self-checking bench for the sinusoid synthesizer
`timescale 1ns/100ps
module testbench;
    import sds_pkg::*;
    localparam int NCH = 2; // channels under test
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b0;
    logic in_valid = 1'b0; // no streamed fields in this build
    sds_in_s in_data = '0;
    logic in_ready;
    logic cfg_valid = 1'b0;
    sds_cfg_s cfg_data = '0;
    logic cfg_ready;
    logic out_valid;
    sds_out_s out_data;
    logic out_ready;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic stall = 1'b0; // sink stalls at random
    logic [15:0] rnd = 16'h3225; // random state
    int miscompares = 0;
    int compares = 0;
    int takes = 0; // samples taken by the sink
    logic rd_prev = 1'b0; // read issued at the previous edge
    sds_out_s exp_q[$]; // expected samples
    logic [31:0] rd_q[$]; // expected read data
    sds_synth #(.NUM_CH(NCH)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .cfg_valid(cfg_valid),
        .cfg_data(cfg_data), .cfg_ready(cfg_ready), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    sds_sink sink (.clk_sys(clk_sys), .stall(stall), .coin(rnd[0]), .out_ready(out_ready));
    always #4 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next
    always @(posedge clk_sys) rnd <= lfsr_next(rnd);
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////
    // watcher: pops the oldest note whenever a result shows up
    always @(posedge clk_sys) begin
        if (rd_prev && rd_q.size() > 0) check("register", 64'(reg_rdata), 64'(rd_q.pop_front()));
        if (rst_b && clk_en && out_valid && out_ready) begin
            takes++;
            if (exp_q.size() > 0) check("sample", 64'(out_data), 64'(exp_q.pop_front()));
        end
        rd_prev = reg_rd;
    end
    ////////////////////////////////////////////////////////////////
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(exp);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : reg_read
    // steps and shifts per channel; valid held until each is taken
    task automatic send_cfg();
        int n;
        for (int c = 0; c < NCH; c++) begin
            cfg_valid <= 1'b1;
            cfg_data <= '{chan: CH_W'(c), cfg_word_step_field: c ? 16'hC000 : 16'h4000,
                cfg_word_shift_field: c ? 16'h4000 : 16'h0000};
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (!(cfg_ready && clk_en) && n < 50);
            if (n >= 50) begin
                miscompares++;
                give_verdict();
            end
        end
        cfg_valid <= 1'b0;
    endtask : send_cfg
    // quarter-turn phases only, so the lookup is exact
    task automatic push_run(input int vecs);
        logic [15:0] sq[4];
        int q;
        sq = '{16'h0000, 16'h7FFF, 16'h0000, 16'h8001};
        for (int n = 0; n < vecs; n++) begin
            for (int c = 0; c < NCH; c++) begin
                q = c ? (3 * n + 1) % 4 : n % 4;
                exp_q.push_back(sds_out_s'{last: c == NCH - 1, chan: CH_W'(c),
                    phase: 16'(q << 14), sine: sq[q], cosine: sq[(q + 1) % 4]});
            end
        end
    endtask : push_run
    task automatic wait_empty();
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 500) begin
            @(posedge clk_sys);
            n++;
        end
        if (exp_q.size() > 0) begin
            miscompares++;
            give_verdict();
        end
    endtask : wait_empty
    ////////////////////////////////////////////////////////////////
    // main sequence; enable stays low until the generator is paused
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk_sys);
        reg_write(REG_CTRL, 32'h2);
        reg_read(REG_CTRL, 32'h2);
        reg_write(REG_STAT, {rnd, rnd});
        reg_write(4'hC, {rnd, rnd});
        reg_read(4'hC, 32'h0);
        reg_read(REG_COUNT, 32'h0);
        clk_en <= 1'b1;
        send_cfg();
        reg_read(REG_STAT, 32'h0003_0000);
        push_run(8);
        stall <= 1'b1;
        reg_write(REG_CTRL, 32'h0);
        repeat (6) @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (4) @(posedge clk_sys);
        clk_en <= 1'b1;
        wait_empty();
        reg_write(REG_CTRL, 32'h2);
        stall <= 1'b0;
        repeat (10) @(posedge clk_sys);
        reg_read(REG_COUNT, 32'(takes));
        // short clear with the generator paused and enable low, two edges long
        clk_en <= 1'b0;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        reg_read(REG_CTRL, {30'h0, CTRL_RST});
        repeat (3) @(posedge clk_sys);
        give_verdict();
    end
endmodule : testbench
bind sds_synth sds_monitor #(.NUM_CH(NUM_CH)) mon (.clk_sys(clk_sys), .rst_b(rst_b),
    .clk_en(clk_en), .in_ready(in_ready), .cfg_ready(cfg_ready), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .reg_rdata(reg_rdata));
